// >>> ats_bus_master.sv
// two-wire bus master model: conditions, bytes and acknowledge bits
// assumes a pull-up on the data line, the clock being driven both ways; the slave samples them with its own clock
`timescale 1ns/1ns
module ats_bus_master (
   // bus lines
   output logic scl,
   output logic sda_drv,
   input wire logic sda_in
);
   // long low phase so the slave's input filter sees hold and setup time
   localparam int HOLD = 120;
   localparam int SETUP = 100;
   localparam int HIGH = 80;
   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b0;
   end
   // start or repeated start; ends with the clock low
   task automatic start_c();
      #HOLD sda_drv = 1'b0;
      #SETUP scl = 1'b1;
      #HIGH sda_drv = 1'b1;
      #HIGH scl = 1'b0;
   endtask : start_c
   task automatic stop_c();
      #HOLD sda_drv = 1'b1;
      #SETUP scl = 1'b1;
      #HIGH sda_drv = 1'b0;
      #HIGH;
   endtask : stop_c
   // data changes only while the clock is low
   task automatic bit_c(input logic b, output logic r);
      #HOLD sda_drv = !b;
      #SETUP scl = 1'b1;
      #(HIGH / 2) r = sda_in;
      #(HIGH / 2) scl = 1'b0;
   endtask : bit_c
   task automatic byte_wr(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_c(d[i], r);
      bit_c(1'b1, r);
      ack = !r;
   endtask : byte_wr
   task automatic byte_rd(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_c(1'b1, d[i]);
      bit_c(!ack, r);
   endtask : byte_rd
endmodule : ats_bus_master

// >>> ats_map.svh
// constants of the two-wire slave port: offsets, field positions, reset values
// assumes inclusion by bare name from the design files
// Functional notes
// RL1: power-on config/setup: single-ended, first input, internal clock
// RL2: result storage holds no assumed value
// RL3: one bit per clock, nine clocks per byte
// RL4: data line steady while clock high
// RL5: detect start and stop conditions
// RL6: repeated start keeps bus and speed mode
// RL7: acknowledge drives data low through ninth pulse
// RL8: not-acknowledge leaves data high on ninth pulse
// RL9: master retries after missing acknowledge
// RL10: own address from base plus select pin
// RL11: idle watches start then own address
// RL12: fast timing after power-up
// RL13: high-speed master code 00001XXX to all
// RL14: not-acknowledge the high-speed master code
// RL15: high-speed mode after that not-acknowledge
// RL16: stop returns to fast timing
// RL17: lines released while bus free
// RL18: acknowledge own write address, accept bytes
// RL19: msb one setup byte, zero config byte
// RL20: monitor flag allows thirteen more bytes
// RL21: foreign address ignored until next start
`ifndef ATS_MAP_SVH
`define ATS_MAP_SVH
`define ATS_REG_CTRL 8'h00
`define ATS_REG_STATUS 8'h04
`define ATS_REG_CONFIG 8'h08
`define ATS_REG_SETUP 8'h0C
`define ATS_REG_MON_BASE 8'h10
`define ATS_CTRL_EN_BIT 0
`define ATS_CTRL_RESTORE_BIT 1
`define ATS_STAT_HS_BIT 0
`define ATS_STAT_BUSY_BIT 1
`define ATS_STAT_ADDRD_BIT 2
`define ATS_STAT_OWN_LSB 8
`define ATS_CONFIG_RST 8'h01
`define ATS_SETUP_RST 8'h80
`define ATS_SETUP_MARK_BIT 7
`define ATS_MON_FLAG_BIT 0
`define ATS_ADDR_BASE_A 7'h34
`define ATS_ADDR_BASE_B 7'h36
`define ATS_HS_CODE 5'h01
`define ATS_MON_DEPTH 13
`define ATS_BYTE_BITS 4'h8
`endif

// >>> ats_pkg.sv
// types of the two-wire slave port
// assumes nothing beyond the compiler
package ats_pkg;
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_ADDR = 9'h002,
      ST_AACK = 9'h004,
      ST_HACK = 9'h008,
      ST_WR = 9'h010,
      ST_WACK = 9'h020,
      ST_RD = 9'h040,
      ST_MACK = 9'h080,
      ST_SKIP = 9'h100
   } ats_state_e;
endpackage : ats_pkg

// >>> ats_slave.sv
// two-wire slave port of the converter: conditions, address, bytes, speed mode
// assumes open-drain lines resolved outside, a master clocking the bus, 50 MHz sys_clk
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "ats_map.svh"
module ats_slave #(
   parameter logic [6:0] ADDR_BASE = `ATS_ADDR_BASE_A,
   parameter int MON_DEPTH = `ATS_MON_DEPTH
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // two-wire link
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // strap
   input wire logic address_select_pin,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // conversion data side
   input wire logic [7:0] res_data,
   output logic res_take,
   // settings
   output logic [7:0] config_byte,
   output logic [7:0] setup_byte,
   output logic hs_mode
);
   import ats_pkg::*;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   ats_state_e state_r;
   logic scl_lvl;
   logic sda_lvl;
   logic sel_lvl;
   logic scl_d_r;
   logic sda_d_r;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   logic [3:0] cnt_r;
   logic byte_done;
   logic [7:0] rx_r;
   logic [7:0] tx_r;
   logic rw_r;
   logic mack_r;
   logic sda_oe_r;
   logic hs_mode_r;
   logic en_r;
   logic restore;
   logic [7:0] config_r;
   logic [7:0] setup_r;
   logic [3:0] mon_cnt_r;
   logic [3:0] mon_idx;
   logic [7:0] mon_mem [MON_DEPTH];
   logic [6:0] own_addr;
   logic addr_hit;
   logic hs_code;
   logic wr_store;
   logic [7:0] mon_off;
   logic mon_sel;
   logic [31:0] rdata_nxt;

   ats_sync #(.RST_VAL(1'b1)) u_scl (.sys_clk(sys_clk), .rst_b(rst_b),
      .d_in(scl_i), .q_lvl(scl_lvl));
   ats_sync #(.RST_VAL(1'b1)) u_sda (.sys_clk(sys_clk), .rst_b(rst_b),
      .d_in(sda_i), .q_lvl(sda_lvl));
   ats_sync #(.RST_VAL(1'b0)) u_sel (.sys_clk(sys_clk), .rst_b(rst_b),
      .d_in(address_select_pin), .q_lvl(sel_lvl));

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         scl_d_r <= scl_lvl;
         sda_d_r <= sda_lvl;
      end
   end

   assign scl_rise = scl_lvl && !scl_d_r;
   assign scl_fall = !scl_lvl && scl_d_r;
   // a data change with the clock high both cycles is a condition, never data
   assign start_ev = scl_lvl && scl_d_r && sda_d_r && !sda_lvl; // RL4 RL5
   assign stop_ev = scl_lvl && scl_d_r && !sda_d_r && sda_lvl; // RL4 RL5
   assign byte_done = (cnt_r == `ATS_BYTE_BITS); // RL3
   assign own_addr = {ADDR_BASE[6:1], sel_lvl}; // RL10
   assign addr_hit = en_r && (rx_r[7:1] == own_addr); // RL10
   assign hs_code = (rx_r[7:3] == `ATS_HS_CODE); // RL13
   assign wr_store = (state_r == ST_WR) && scl_fall && byte_done && !start_ev && !stop_ev;
   assign mon_idx = 4'(MON_DEPTH) - mon_cnt_r;
   assign restore = reg_wr && (reg_addr == `ATS_REG_CTRL) && reg_wdata[`ATS_CTRL_RESTORE_BIT];

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         state_r <= ST_IDLE;
      else if (stop_ev)
         state_r <= ST_IDLE; // RL5
      else if (start_ev)
         state_r <= ST_ADDR; // RL5 RL6 RL11
      else if (scl_fall)
      begin
         case (state_r)
            ST_ADDR:
               if (byte_done)
                  state_r <= addr_hit ? ST_AACK : (hs_code ? ST_HACK : ST_SKIP); // RL11 RL21
            ST_AACK: state_r <= rw_r ? ST_RD : ST_WR; // RL11 RL18
            ST_HACK: state_r <= ST_SKIP; // RL15
            ST_WR:
               if (byte_done)
                  state_r <= ST_WACK;
            ST_WACK: state_r <= ST_WR;
            ST_RD:
               if (byte_done)
                  state_r <= ST_MACK;
            // a master not-acknowledge ends the read; wait for the next condition
            ST_MACK: state_r <= mack_r ? ST_SKIP : ST_RD;
            ST_IDLE, ST_SKIP: state_r <= state_r;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // bit counter: eight data clocks, then the ninth is the acknowledge clock
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_r <= 4'h0;
      else if (start_ev || stop_ev)
         cnt_r <= 4'h0;
      else if (scl_rise && !byte_done && (state_r inside {ST_ADDR, ST_WR, ST_RD}))
         cnt_r <= cnt_r + 4'h1; // RL3
      else if (scl_fall && (state_r inside {ST_AACK, ST_WACK, ST_MACK, ST_HACK}))
         cnt_r <= 4'h0; // RL3
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_r <= 8'h00;
         rw_r <= 1'b0;
         mack_r <= 1'b1;
      end
      else
      begin
         if (scl_rise && !byte_done && (state_r inside {ST_ADDR, ST_WR}))
            rx_r <= {rx_r[6:0], sda_lvl};
         if (state_r == ST_ADDR && scl_fall && byte_done)
            rw_r <= rx_r[0];
         if (state_r == ST_MACK && scl_rise)
            mack_r <= sda_lvl; // RL8
      end
   end

   // each byte is taken fresh from the data side; nothing stored is assumed
   assign res_take = scl_fall && !start_ev && !stop_ev
      && ((state_r == ST_AACK && rw_r) || (state_r == ST_MACK && !mack_r)); // RL2

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         tx_r <= 8'hFF;
      else if (res_take)
         tx_r <= res_data; // RL2
      else if (state_r == ST_RD && scl_fall)
         tx_r <= {tx_r[6:0], 1'b1};
   end

   // data line is changed only just after a clock fall, apart from the release on a start or stop condition
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         sda_oe_r <= 1'b0; // RL17
      else if (start_ev || stop_ev)
         sda_oe_r <= 1'b0; // RL17
      else if (scl_fall)
      begin
         case (state_r)
            ST_ADDR: sda_oe_r <= byte_done && addr_hit; // RL7 RL18 RL21 RL14
            ST_WR: sda_oe_r <= byte_done; // RL7 RL20
            ST_AACK: sda_oe_r <= rw_r && !res_data[7];
            ST_RD: sda_oe_r <= !byte_done && !tx_r[6]; // RL4
            ST_MACK: sda_oe_r <= !mack_r && !res_data[7];
            default: sda_oe_r <= 1'b0; // RL8
         endcase
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe = sda_oe_r;

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         hs_mode_r <= 1'b0; // RL12
      else if (stop_ev)
         hs_mode_r <= 1'b0; // RL16
      else if (state_r == ST_HACK && scl_fall && !start_ev)
         hs_mode_r <= 1'b1; // RL15
   end

   assign hs_mode = hs_mode_r;

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         en_r <= 1'b1;
      else if (reg_wr && reg_addr == `ATS_REG_CTRL)
         en_r <= reg_wdata[`ATS_CTRL_EN_BIT];
   end

   // a byte from the link in the same cycle as a restore wins, as the newer setting
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         config_r <= `ATS_CONFIG_RST; // RL1
         setup_r <= `ATS_SETUP_RST; // RL1
      end
      else if (wr_store && mon_cnt_r == 4'h0)
      begin
         if (rx_r[`ATS_SETUP_MARK_BIT])
            setup_r <= rx_r; // RL19
         else
            config_r <= rx_r; // RL19
      end
      else if (restore)
      begin
         config_r <= `ATS_CONFIG_RST; // RL1
         setup_r <= `ATS_SETUP_RST; // RL1
      end
   end

   assign config_byte = config_r;
   assign setup_byte = setup_r;

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         mon_cnt_r <= 4'h0;
      else if (start_ev || stop_ev)
         mon_cnt_r <= 4'h0; // RL20
      else if (wr_store)
      begin
         if (mon_cnt_r != 4'h0)
            mon_cnt_r <= mon_cnt_r - 4'h1; // RL20
         else if (rx_r[`ATS_SETUP_MARK_BIT] && rx_r[`ATS_MON_FLAG_BIT])
            mon_cnt_r <= 4'(MON_DEPTH); // RL20
      end
   end

   // monitor data is plain storage with no reset; content is unknown until written
   always_ff @(posedge sys_clk)
   begin
      if (wr_store && mon_cnt_r != 4'h0)
         mon_mem[mon_idx] <= rx_r; // RL20
   end

   assign mon_off = reg_addr - `ATS_REG_MON_BASE;
   assign mon_sel = (reg_addr >= `ATS_REG_MON_BASE) && (mon_off[1:0] == 2'h0)
      && (mon_off[7:2] < 6'(MON_DEPTH));

   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      if (mon_sel)
         rdata_nxt[7:0] = mon_mem[mon_off[5:2]];
      else
      begin
         case (reg_addr)
            `ATS_REG_CTRL: rdata_nxt[`ATS_CTRL_EN_BIT] = en_r;
            `ATS_REG_STATUS:
            begin
               rdata_nxt[`ATS_STAT_HS_BIT] = hs_mode_r;
               rdata_nxt[`ATS_STAT_BUSY_BIT] = (state_r != ST_IDLE);
               rdata_nxt[`ATS_STAT_ADDRD_BIT] = state_r inside {ST_AACK, ST_WR, ST_WACK,
                  ST_RD, ST_MACK};
               rdata_nxt[`ATS_STAT_OWN_LSB +: 7] = own_addr;
            end
            `ATS_REG_CONFIG: rdata_nxt[7:0] = config_r;
            `ATS_REG_SETUP: rdata_nxt[7:0] = setup_r;
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // read data stands for exactly the cycle after the strobe
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         reg_rdata <= 32'h0000_0000;
      else if (reg_rd)
         reg_rdata <= rdata_nxt;
      else
         reg_rdata <= 32'h0000_0000;
   end

   a_start_addr: assert property (start_ev && !stop_ev
      |=> state_r == ST_ADDR && cnt_r == 4'h0) // RL5
      else $error("start not followed by address phase");
   a_cnt_bound: assert property (cnt_r <= `ATS_BYTE_BITS) // RL3
      else $error("bit counter past eight");
   a_ack_drive: assert property ((state_r == ST_AACK || state_r == ST_WACK) && scl_lvl
      |-> sda_oe_r) // RL7
      else $error("acknowledge not held low in ninth clock");
   a_hs_nack: assert property (state_r == ST_HACK |-> !sda_oe_r) // RL14
      else $error("high-speed code was acknowledged");
   a_hs_entry: assert property (state_r == ST_HACK && scl_fall && !start_ev && !stop_ev
      |=> hs_mode_r && state_r == ST_SKIP) // RL15
      else $error("high-speed mode not entered after code");
   a_stop_fast: assert property (stop_ev |=> !hs_mode_r ##0 state_r == ST_IDLE) // RL16
      else $error("stop did not restore fast timing");
   a_rstart_keep: assert property (start_ev && !stop_ev && hs_mode_r |=> hs_mode_r [*2]) // RL6
      else $error("repeated start dropped high-speed mode");
   a_free_release: assert property (state_r inside {ST_IDLE, ST_SKIP, ST_HACK}
      |-> !sda_oe_r) // RL17
      else $error("data line driven while not addressed");
   a_hold_high: assert property ($changed(sda_oe_r) |-> !scl_lvl) // RL4
      else $error("data line changed with clock high");
   a_addr_ack: assert property (state_r == ST_ADDR && scl_fall && byte_done && addr_hit
      && !start_ev && !stop_ev |=> state_r == ST_AACK && sda_oe_r) // RL18
      else $error("own address not acknowledged");
   a_foreign_skip: assert property (state_r == ST_ADDR && scl_fall && byte_done && !addr_hit
      && !hs_code && !start_ev && !stop_ev |=> state_r == ST_SKIP [*1] ##1 !sda_oe_r) // RL21
      else $error("foreign address not ignored");
   a_cfg_store: assert property (wr_store && mon_cnt_r == 4'h0 && !rx_r[7]
      |=> config_r == $past(rx_r)) // RL19
      else $error("configuration byte not stored");
   a_mon_arm: assert property (wr_store && mon_cnt_r == 4'h0 && rx_r[7] && rx_r[0]
      |=> mon_cnt_r == 4'(MON_DEPTH) && setup_r == $past(rx_r)) // RL20
      else $error("monitor data count not armed");
endmodule : ats_slave

// >>> ats_sync.sv
// three-stage input synchroniser with agreement filter
// assumes an asynchronous input and the system clock domain
`timescale 1ns/1ns
module ats_sync #(
   parameter logic RST_VAL = 1'b1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // pin and filtered level
   input wire logic d_in,
   output logic q_lvl
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
      end
      else
      begin
         s1_r <= d_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // only a level held by two later stages counts, so a one-cycle glitch is lost
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         q_lvl <= RST_VAL;
      else if (s2_r == s3_r)
         q_lvl <= s3_r;
   end
endmodule : ats_sync

// >>> tb.sv
// self-checking bench of the two-wire slave port with a behavioural bus master
// assumes the handed-over register map and link timing; pull-up on the data line
`timescale 1ns/1ns
module tb;
   logic sys_clk, rst_b, sel, reg_wr, reg_rd, scl, m_drv, sda, ack;
   logic sda_o, sda_oe, res_take, hs_mode;
   logic [7:0] reg_addr, res_data, config_byte, setup_byte, d, cfg, stp;
   logic [31:0] reg_wdata, reg_rdata, v;
   logic [6:0] own;
   logic [7:0] mon [13];
   int err_total, num_checks, takes;
   // open drain: either party pulls low, otherwise the pull-up wins
   assign sda = !((sda_oe && !sda_o) || m_drv);
   ats_slave ats_slave_i (.sys_clk(sys_clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .address_select_pin(sel), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .res_data(res_data), .res_take(res_take), .config_byte(config_byte),
      .setup_byte(setup_byte), .hs_mode(hs_mode));
   ats_bus_master ats_bus_master_i (.scl(scl), .sda_drv(m_drv), .sda_in(sda));
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
      if (res_take === 1'b1)
         takes++;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string w);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, w, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   task automatic reg_w(input logic [7:0] a, input logic [31:0] x);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= x;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : reg_w
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string w);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      check(reg_rdata, exp, w);
   endtask : rchk
   task automatic wb(input logic [7:0] x, input logic e, input string w);
      ats_bus_master_i.byte_wr(x, ack);
      check(ack, e, w);
   endtask : wb
   task automatic frame(input logic rw, input logic e, input string w);
      ats_bus_master_i.start_c();
      wb({own, rw}, e, w);
   endtask : frame
   task automatic settle();
      repeat (8) @(posedge sys_clk);
   endtask : settle
   initial
   begin
      repeat (100000) @(posedge sys_clk);
      err_total++;
      print_verdict();
   end
   initial
   begin
      {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, res_data} = '0;
      err_total = 0;
      num_checks = 0;
      takes = 0;
      v = $urandom(59489);
      sel = v[0];
      own = {6'h1A, sel};
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      settle();
      check(config_byte, 8'h01, "config default");
      check(setup_byte, 8'h80, "setup default");
      check(hs_mode, 1'b0, "fast after reset");
      check(sda_oe, 1'b0, "line released");
      check(sda_o, 1'b0, "open drain value");
      rchk(8'h08, 32'h01, "config reg");
      rchk(8'h0C, 32'h80, "setup reg");
      rchk(8'h04, {17'h0, own, 8'h00}, "status");
      rchk(8'h44, 32'h0, "unmapped");
      $display("test reset done");
      repeat (4)
      begin
         cfg = 8'($urandom) & 8'h7F;
         stp = (8'($urandom) & 8'h7E) | 8'h80;
         frame(1'b0, 1'b1, "own address");
         wb(cfg, 1'b1, "config ack");
         wb(stp, 1'b1, "setup ack");
         ats_bus_master_i.stop_c();
         check(config_byte, cfg, "config");
         check(setup_byte, stp, "setup");
      end
      ats_bus_master_i.start_c();
      wb({own ^ 7'h02, 1'b0}, 1'b0, "foreign address");
      wb(8'h00, 1'b0, "foreign data");
      ats_bus_master_i.stop_c();
      check(config_byte, cfg, "config kept");
      $display("test write done");
      frame(1'b0, 1'b1, "monitor address");
      wb(8'h81, 1'b1, "monitor setup");
      for (int i = 0; i < 13; i++)
      begin
         mon[i] = 8'($urandom);
         wb(mon[i], 1'b1, "monitor byte");
      end
      wb(8'h2A, 1'b1, "byte after monitor");
      ats_bus_master_i.stop_c();
      check(config_byte, 8'h2A, "parsed again");
      for (int i = 0; i < 13; i++)
         rchk(8'h10 + 8'(4 * i), {24'h0, mon[i]}, "monitor data");
      frame(1'b0, 1'b1, "early end address");
      wb(8'h81, 1'b1, "early setup");
      wb(8'h55, 1'b1, "early byte");
      frame(1'b0, 1'b1, "after repeated start");
      wb(8'h11, 1'b1, "config after sr");
      ats_bus_master_i.stop_c();
      check(config_byte, 8'h11, "config after sr");
      $display("test monitor done");
      ats_bus_master_i.start_c();
      wb({5'h01, 3'($urandom)}, 1'b0, "hs code nack");
      settle();
      check(hs_mode, 1'b1, "hs entered");
      frame(1'b0, 1'b1, "hs address");
      wb(8'h13, 1'b1, "hs config");
      check(hs_mode, 1'b1, "hs kept");
      ats_bus_master_i.stop_c();
      settle();
      check(hs_mode, 1'b0, "fast after stop");
      $display("test speed done");
      @(posedge sys_clk);
      res_data <= 8'($urandom);
      takes = 0;
      frame(1'b1, 1'b1, "read address");
      ats_bus_master_i.byte_rd(1'b1, d);
      check(d, res_data, "read byte 1");
      ats_bus_master_i.byte_rd(1'b0, d);
      check(d, res_data, "read byte 2");
      ats_bus_master_i.stop_c();
      check(takes, 2, "bytes taken");
      $display("test read done");
      reg_w(8'h00, 32'h0);
      frame(1'b0, 1'b0, "disabled");
      ats_bus_master_i.stop_c();
      reg_w(8'h00, 32'h1);
      frame(1'b0, 1'b1, "retry");
      wb(8'h7F, 1'b1, "retry data");
      ats_bus_master_i.stop_c();
      check(config_byte, 8'h7F, "retry config");
      reg_w(8'h00, 32'h3);
      @(negedge sys_clk);
      check(config_byte, 8'h01, "restored");
      check(setup_byte, 8'h80, "setup restored");
      $display("test control done");
      print_verdict();
   end
endmodule : tb
